// >>> src/reload_timer_defs.vh
// register map, field positions, reset values and counts of the reload timer
`ifndef RELOAD_TIMER_DEFS_VH
`define RELOAD_TIMER_DEFS_VH

// --------------------------------------------------------------
// register indices, byte address is four times the index
// --------------------------------------------------------------
`define IDX_DUTY3 7'h73
`define IDX_DUTY2 7'h74
`define IDX_DUTY1 7'h75
`define IDX_DUTY0 7'h76
`define IDX_OUTCTL 7'h77
`define IDX_CSR 7'h78
`define IDX_CNT 7'h79
`define IDX_RELOAD 7'h7A
`define IDX_CAPCSR 7'h7B
`define IDX_CAP1 7'h7C
`define IDX_CAP2 7'h7D

// --------------------------------------------------------------
// timer_control_status fields
// --------------------------------------------------------------
`define CSR_CLKSRC 7
`define CSR_DIV_HI 6
`define CSR_DIV_LO 4
`define CSR_ENABLE 3
`define CSR_FORCE 2
`define CSR_OVFIE 1
`define CSR_OVF 0

// --------------------------------------------------------------
// output_control_reg and capture_control_status fields
// --------------------------------------------------------------
`define OUT_OE_HI 7
`define OUT_OE_LO 4
`define OUT_POL_HI 3
`define OUT_POL_LO 0
`define CAP_EDGE_LO 4
`define CAP_IE_LO 2
`define CAP_FLAG_LO 0

// --------------------------------------------------------------
// reset values and counts
// --------------------------------------------------------------
`define RST_BYTE 8'h00
`define CNT_TOP 8'hFF
`define PRE_WIDTH 7

`endif

// >>> src/capture_channel.v
// one input capture channel with edge select, hold-until-read and flag
`include "reload_timer_defs.vh"

module capture_channel (
  input wire clk,
  input wire rst,
  input wire pinLevel,
  input wire edgeRising,
  input wire [7:0] counterValue,
  input wire clearByRead,
  output reg [7:0] captureValue_r,
  output reg captureFlag_r
);

  // --------------------------------------------------------------
  // edge detection
  // --------------------------------------------------------------
  reg pinPrev_r;
  wire riseSeen;
  wire fallSeen;
  wire edgeHit;
  wire mayLoad;

  // pin is synchronous already, so one stage of history suffices
  assign riseSeen = pinLevel & ~pinPrev_r;
  assign fallSeen = ~pinLevel & pinPrev_r;
  assign edgeHit = edgeRising ? riseSeen : fallSeen;
  // a read in the same cycle reopens the register, so the edge is not lost
  assign mayLoad = ~captureFlag_r | clearByRead;

  // --------------------------------------------------------------
  // latch and flag
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pinPrev_r <= 1'b0;
      captureValue_r <= `RST_BYTE;
      captureFlag_r <= 1'b0;
    end else begin
      pinPrev_r <= pinLevel;
      if (edgeHit && mayLoad) begin
        captureValue_r <= counterValue;
        captureFlag_r <= 1'b1;
      end else if (clearByRead) begin
        captureFlag_r <= 1'b0;
      end
    end
  end

endmodule // capture_channel

// >>> src/pwm_auto_reload_timer.v
// eight-bit auto-reload pwm timer with prescaler, capture and wishbone slave
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`include "reload_timer_defs.vh"

module pwm_auto_reload_timer (
  input wire clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [8:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  output reg [31:0] wbDatR_r,
  output reg wbAck_r,
  input wire externalClock,
  input wire haltMode,
  input wire [1:0] captureInputPin,
  output reg [3:0] modulatedOutputPin_r,
  output reg [3:0] pinOutputEnable_r,
  output reg overflowIrq_r,
  output reg [1:0] captureIrq_r,
  output reg wakeUp_r
);

  // --------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------
  // word index match on the byte address
  function regHit;
    input [8:0] adr;
    input [6:0] idx;
    begin
      regHit = (adr[8:2] == idx);
    end
  endfunction

  // high when the low n prescaler bits are all ones
  function tapHit;
    input [6:0] pre;
    input [2:0] n;
    reg [7:0] mask;
    begin
      mask = (8'h01 << n) - 8'h01;
      tapHit = ((pre & mask[6:0]) == mask[6:0]);
    end
  endfunction

  // --------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------
  reg clockSourceSelect_r;
  reg [2:0] dividerSelect_r;
  reg countEnable_r;
  reg overflowIrqEnable_r;
  reg overflowFlag_r;
  reg [7:0] reloadValueReg_r;
  reg [7:0] dutySettingReg_r [0:3];
  reg [3:0] channelOutputEnable_r;
  reg [3:0] polaritySelect_r;
  reg [1:0] captureEdgeSelect_r;
  reg [1:0] captureIrqEnable_r;

  // --------------------------------------------------------------
  // timing state
  // --------------------------------------------------------------
  reg [`PRE_WIDTH-1:0] prescaler_r;
  reg [7:0] counter_r;
  reg [7:0] compareShadowReg_r [0:3];
  reg [3:0] activePhase_r;
  reg extPrev_r;

  wire [7:0] captureValue1;
  wire [7:0] captureValue2;
  wire [1:0] captureFlag;

  // --------------------------------------------------------------
  // bus access
  // --------------------------------------------------------------
  wire access;
  wire wrStrobe;
  wire rdStrobe;
  wire wrFrozen;
  wire wrCsr;
  wire wrCnt;
  wire wrReload;
  wire wrOutCtl;
  wire wrCapCsr;
  wire rdCsr;
  wire rdCap1;
  wire rdCap2;
  wire [7:0] wrByte;

  // one access per request; ack_r high blocks a repeat on the held request
  assign access = wbCyc & wbStb & ~wbAck_r;
  assign wrStrobe = access & wbWe & wbSel[0];
  assign rdStrobe = access & ~wbWe;
  assign wrByte = wbDatW[7:0];
  // while halted, on either clock, the control registers hold still
  assign wrFrozen = haltMode;
  assign wrCsr = wrStrobe & ~wrFrozen & regHit(wbAdr, `IDX_CSR);
  assign wrCnt = wrStrobe & ~wrFrozen & regHit(wbAdr, `IDX_CNT);
  assign wrReload = wrStrobe & ~wrFrozen & regHit(wbAdr, `IDX_RELOAD);
  assign wrOutCtl = wrStrobe & ~wrFrozen & regHit(wbAdr, `IDX_OUTCTL);
  assign wrCapCsr = wrStrobe & ~wrFrozen & regHit(wbAdr, `IDX_CAPCSR);
  assign rdCsr = rdStrobe & regHit(wbAdr, `IDX_CSR);
  assign rdCap1 = rdStrobe & regHit(wbAdr, `IDX_CAP1);
  assign rdCap2 = rdStrobe & regHit(wbAdr, `IDX_CAP2);

  // --------------------------------------------------------------
  // clock selection and prescaler taps
  // --------------------------------------------------------------
  wire extRise;
  wire inputTick;
  wire running;
  wire counterTick;
  wire overflow;
  wire forceLoad;
  wire restartPre;

  assign extRise = externalClock & ~extPrev_r;
  assign inputTick = clockSourceSelect_r ? extRise : 1'b1;
  // halted on the cpu clock nothing moves; on the external clock it counts
  assign running = countEnable_r & (~haltMode | clockSourceSelect_r);
  assign counterTick = running & inputTick & tapHit(prescaler_r, dividerSelect_r);
  assign overflow = counterTick & (counter_r == `CNT_TOP);
  assign forceLoad = wrCsr & wrByte[`CSR_FORCE];
  assign restartPre = forceLoad | wrCnt;

  // external clock history for edge detection
  always @(posedge clk) begin
    if (rst) begin
      extPrev_r <= 1'b0;
    end else begin
      extPrev_r <= externalClock;
    end
  end

  // prescaler advances on each selected input tick while running
  always @(posedge clk) begin
    if (rst) begin
      prescaler_r <= {`PRE_WIDTH{1'b0}};
    end else if (restartPre) begin
      prescaler_r <= {`PRE_WIDTH{1'b0}};
    end else if (running && inputTick) begin
      prescaler_r <= prescaler_r + 7'h01;
    end
  end

  // --------------------------------------------------------------
  // counter
  // --------------------------------------------------------------
  // software loads win over a tick in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      counter_r <= `RST_BYTE;
    end else if (wrCnt) begin
      counter_r <= wrByte;
    end else if (forceLoad) begin
      counter_r <= reloadValueReg_r;
    end else if (overflow) begin
      counter_r <= reloadValueReg_r;
    end else if (counterTick) begin
      counter_r <= counter_r + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // control and status registers
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      clockSourceSelect_r <= 1'b0;
      dividerSelect_r <= 3'h0;
      countEnable_r <= 1'b0;
      overflowIrqEnable_r <= 1'b0;
      reloadValueReg_r <= `RST_BYTE;
      channelOutputEnable_r <= 4'h0;
      polaritySelect_r <= 4'h0;
      captureEdgeSelect_r <= 2'h0;
      captureIrqEnable_r <= 2'h0;
    end else begin
      if (wrCsr) begin
        clockSourceSelect_r <= wrByte[`CSR_CLKSRC];
        dividerSelect_r <= wrByte[`CSR_DIV_HI:`CSR_DIV_LO];
        countEnable_r <= wrByte[`CSR_ENABLE];
        overflowIrqEnable_r <= wrByte[`CSR_OVFIE];
      end
      if (wrReload) begin
        reloadValueReg_r <= wrByte;
      end
      if (wrOutCtl) begin
        channelOutputEnable_r <= wrByte[`OUT_OE_HI:`OUT_OE_LO];
        polaritySelect_r <= wrByte[`OUT_POL_HI:`OUT_POL_LO];
      end
      if (wrCapCsr) begin
        captureEdgeSelect_r <= wrByte[`CAP_EDGE_LO+1:`CAP_EDGE_LO];
        captureIrqEnable_r <= wrByte[`CAP_IE_LO+1:`CAP_IE_LO];
      end
    end
  end

  // overflow flag: an overflow in the clearing read cycle keeps it set
  always @(posedge clk) begin
    if (rst) begin
      overflowFlag_r <= 1'b0;
    end else if (overflow) begin
      overflowFlag_r <= 1'b1;
    end else if (rdCsr) begin
      overflowFlag_r <= 1'b0;
    end
  end

  // duty registers sit behind four consecutive indices, highest channel first
  integer i, j, k;
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        dutySettingReg_r[i] <= `RST_BYTE;
      end
    end else if (wrStrobe && !wrFrozen) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (regHit(wbAdr, `IDX_DUTY0 - i[6:0])) begin
          dutySettingReg_r[i] <= wrByte;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // compare shadows and pwm phase
  // --------------------------------------------------------------
  // shadows only move on overflow, so a duty change never cuts a period short
  always @(posedge clk) begin
    if (rst) begin
      for (j = 0; j < 4; j = j + 1) begin
        compareShadowReg_r[j] <= `RST_BYTE;
      end
    end else if (overflow) begin
      for (j = 0; j < 4; j = j + 1) begin
        compareShadowReg_r[j] <= dutySettingReg_r[j];
      end
    end
  end

  // phase is high from overflow until the counter steps past its compare;
  // a compare below the reload value therefore never ends the phase
  always @(posedge clk) begin
    if (rst) begin
      activePhase_r <= 4'h0;
    end else if (!haltMode) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (overflow) begin
          activePhase_r[k] <= 1'b1;
        end else if (counterTick && counter_r == compareShadowReg_r[k]) begin
          activePhase_r[k] <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------
  // polarity acts at once; pins keep their level while halted
  always @(posedge clk) begin
    if (rst) begin
      modulatedOutputPin_r <= 4'h0;
      pinOutputEnable_r <= 4'h0;
    end else begin
      pinOutputEnable_r <= channelOutputEnable_r;
      if (!haltMode) begin
        modulatedOutputPin_r <= (activePhase_r ^ polaritySelect_r)
                                & channelOutputEnable_r;
      end
    end
  end

  // --------------------------------------------------------------
  // capture channels
  // --------------------------------------------------------------
  capture_channel captureOne (
    .clk(clk),
    .rst(rst),
    .pinLevel(captureInputPin[0]),
    .edgeRising(captureEdgeSelect_r[0]),
    .counterValue(counter_r),
    .clearByRead(rdCap1),
    .captureValue_r(captureValue1),
    .captureFlag_r(captureFlag[0])
  );

  capture_channel captureTwo (
    .clk(clk),
    .rst(rst),
    .pinLevel(captureInputPin[1]),
    .edgeRising(captureEdgeSelect_r[1]),
    .counterValue(counter_r),
    .clearByRead(rdCap2),
    .captureValue_r(captureValue2),
    .captureFlag_r(captureFlag[1])
  );

  // --------------------------------------------------------------
  // interrupt requests and wake-up
  // --------------------------------------------------------------
  wire overflowPending;
  wire [1:0] capturePending;

  assign overflowPending = overflowFlag_r & overflowIrqEnable_r;
  assign capturePending = captureFlag & captureIrqEnable_r;

  // requests are levels that stay up until their flag is cleared
  always @(posedge clk) begin
    if (rst) begin
      overflowIrq_r <= 1'b0;
      captureIrq_r <= 2'h0;
      wakeUp_r <= 1'b0;
    end else begin
      overflowIrq_r <= overflowPending;
      captureIrq_r <= capturePending;
      wakeUp_r <= haltMode & (overflowPending | (|capturePending));
    end
  end

  // --------------------------------------------------------------
  // read mux and acknowledge
  // --------------------------------------------------------------
  reg [7:0] rdByte;

  // unmapped indices read as zero; force_reload always reads zero
  always @* begin
    rdByte = 8'h00;
    if (regHit(wbAdr, `IDX_CSR)) begin
      rdByte = {clockSourceSelect_r, dividerSelect_r, countEnable_r,
                1'b0, overflowIrqEnable_r, overflowFlag_r};
    end else if (regHit(wbAdr, `IDX_CNT)) begin
      rdByte = counter_r;
    end else if (regHit(wbAdr, `IDX_RELOAD)) begin
      rdByte = reloadValueReg_r;
    end else if (regHit(wbAdr, `IDX_OUTCTL)) begin
      rdByte = {channelOutputEnable_r, polaritySelect_r};
    end else if (regHit(wbAdr, `IDX_CAPCSR)) begin
      rdByte = {2'b00, captureEdgeSelect_r, captureIrqEnable_r, captureFlag};
    end else if (regHit(wbAdr, `IDX_CAP1)) begin
      rdByte = captureValue1;
    end else if (regHit(wbAdr, `IDX_CAP2)) begin
      rdByte = captureValue2;
    end else if (regHit(wbAdr, `IDX_DUTY0)) begin
      rdByte = dutySettingReg_r[0];
    end else if (regHit(wbAdr, `IDX_DUTY1)) begin
      rdByte = dutySettingReg_r[1];
    end else if (regHit(wbAdr, `IDX_DUTY2)) begin
      rdByte = dutySettingReg_r[2];
    end else if (regHit(wbAdr, `IDX_DUTY3)) begin
      rdByte = dutySettingReg_r[3];
    end
  end

  // every access, mapped or not, is answered one cycle after it is seen
  always @(posedge clk) begin
    if (rst) begin
      wbAck_r <= 1'b0;
      wbDatR_r <= 32'h0000_0000;
    end else begin
      wbAck_r <= access;
      if (rdStrobe) begin
        wbDatR_r <= {24'h00_0000, rdByte};
      end
    end
  end

endmodule // pwm_auto_reload_timer

// >>> tb/reload_timer_checker.sv
// concurrent checks on the ports of the reload timer
`include "reload_timer_defs.vh"
module reload_timer_checker (
  input wire clk,
  input wire rst,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [8:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  input wire [31:0] wbDatR_r,
  input wire wbAck_r,
  input wire haltMode,
  input wire [3:0] modulatedOutputPin_r,
  input wire [3:0] pinOutputEnable_r,
  input wire overflowIrq_r,
  input wire [1:0] captureIrq_r,
  input wire wakeUp_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // request taken, status read answered, enable write taken
  wire taken = wbCyc && wbStb && !wbAck_r;
  wire rdCsr = wbAck_r && !wbWe && wbAdr[8:2] == `IDX_CSR;
  wire wrOut = taken && wbWe && wbSel[0] && !haltMode && wbAdr[8:2] == `IDX_OUTCTL;
  a_ack_after_take: assert property (taken |=> wbAck_r)
    else $error("ack missing after request");
  a_ack_single: assert property (wbAck_r |=> !wbAck_r)
    else $error("ack longer than one cycle");
  a_force_reads_zero: assert property (rdCsr |-> wbDatR_r[2] == 1'b0)
    else $error("force bit read back as one");
  a_pin_gated: assert property ((modulatedOutputPin_r & ~pinOutputEnable_r) == 4'h0)
    else $error("disabled pin driven high");
  a_enable_follows: assert property (wrOut |-> ##2
    pinOutputEnable_r == $past(wbDatW[7:4], 2))
    else $error("pin enables do not follow write");
  a_ovf_irq_off: assert property (rdCsr && !wbDatR_r[1] |=> !overflowIrq_r)
    else $error("overflow irq while disabled");
  a_wake_in_halt: assert property ($past(haltMode) && overflowIrq_r |-> wakeUp_r)
    else $error("no wake on pending overflow");
  a_no_wake_awake: assert property (!$past(haltMode) |-> !wakeUp_r)
    else $error("wake while not halted");
  a_halt_pins_hold: assert property (haltMode [*4] |-> $stable(modulatedOutputPin_r))
    else $error("pwm pins move in halt");
  // main scenarios reached
  c_ovf: cover property (overflowIrq_r);
  c_cap: cover property (captureIrq_r[0]);
  c_wake: cover property (wakeUp_r);
endmodule // reload_timer_checker

bind pwm_auto_reload_timer reload_timer_checker reload_timer_checker_i (
  .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
  .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR_r(wbDatR_r), .wbAck_r(wbAck_r),
  .haltMode(haltMode), .modulatedOutputPin_r(modulatedOutputPin_r),
  .pinOutputEnable_r(pinOutputEnable_r), .overflowIrq_r(overflowIrq_r),
  .captureIrq_r(captureIrq_r), .wakeUp_r(wakeUp_r));

// >>> tb/pin_partner.sv
// model of the pins around the timer: event clock, capture inputs, pwm meters
module pin_partner (
  input wire clk,
  input wire [3:0] pwmPin,
  output logic extClk,
  output logic [1:0] capPin
);
  timeunit 1ns;
  timeprecision 1ps;
  int per [4];
  int hiW [4];
  int hi [4];
  int run [4];
  logic [3:0] last;
  // event clock stands low between bursts; capture lines idle high
  initial begin
    extClk = 1'b0;
    capPin = 2'b11;
    last = 4'h0;
  end
  // one rising edge per counted event, held long enough to be seen
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) extClk <= 1'b1;
      repeat (2) @(posedge clk);
      extClk <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // low then high pulse: gives one edge of each kind
  task automatic capPulse(input int ch);
    @(posedge clk) capPin[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    capPin[ch] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // period from rise to rise and width of the last high phase
  always @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      run[c] <= (pwmPin[c] && !last[c]) ? 1 : run[c] + 1;
      if (pwmPin[c] && !last[c]) per[c] <= run[c];
      hi[c] <= pwmPin[c] ? hi[c] + 1 : 0;
      if (!pwmPin[c] && last[c]) hiW[c] <= hi[c];
    end
    last <= pwmPin;
  end
endmodule // pin_partner

// >>> tb/pwm_auto_reload_timer_tb.sv
// self-checking bench of the pwm auto-reload timer
`include "reload_timer_defs.vh"
module pwm_auto_reload_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wbCyc, wbStb, wbWe, haltMode;
  logic [8:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, a, b;
  wire [31:0] wbDatR_r;
  wire wbAck_r, externalClock, overflowIrq_r, wakeUp_r;
  wire [1:0] captureInputPin, captureIrq_r;
  wire [3:0] modulatedOutputPin_r, pinOutputEnable_r;
  int bad_count, checks_done;

  pwm_auto_reload_timer pwm_auto_reload_timer_i (
    .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR_r(wbDatR_r), .wbAck_r(wbAck_r),
    .externalClock(externalClock), .haltMode(haltMode), .captureInputPin(captureInputPin),
    .modulatedOutputPin_r(modulatedOutputPin_r), .pinOutputEnable_r(pinOutputEnable_r),
    .overflowIrq_r(overflowIrq_r), .captureIrq_r(captureIrq_r), .wakeUp_r(wakeUp_r));
  pin_partner pin_partner_i (.clk(clk), .pwmPin(modulatedOutputPin_r),
    .extClk(externalClock), .capPin(captureInputPin));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude;
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single wishbone cycle; request held until the edge that samples ack high,
  // data taken at that edge; only the watchdog ends a wait that never returns
  task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatW <= {24'h0, d};
    @(posedge clk);
    while (wbAck_r !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    check(n, 32'h0000_0001); // ack one cycle after the taking edge
    q = wbDatR_r;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, a);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, b);
    check(b, {24'h0, exp});
  endtask

  task automatic t_reset;
    for (int i = 115; i <= 125; i++) rdc(7'(i), 8'h00);
    wr(7'h00, 8'hA5);
    rdc(7'h00, 8'h00);
  endtask

  task automatic t_force;
    wr(`IDX_RELOAD, 8'h40);
    wr(`IDX_CSR, 8'h04);
    rdc(`IDX_CNT, 8'h40);
    rdc(`IDX_CSR, 8'h00);
    wr(`IDX_CNT, 8'h77);
    repeat (20) @(posedge clk);
    rdc(`IDX_CNT, 8'h77);
  endtask

  // read-to-read spacing is a whole number of divider periods, so phase drops out
  task automatic t_divider;
    wr(`IDX_RELOAD, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(`IDX_CSR, {1'b0, 3'(n), 4'h8});
      wb(1'b0, `IDX_CNT, 8'h00, a);
      repeat ((4 << n) - 3) @(posedge clk);
      wb(1'b0, `IDX_CNT, 8'h00, b);
      check({24'h0, b[7:0] - a[7:0]}, 32'h0000_0004);
    end
  endtask

  task automatic t_overflow;
    wr(`IDX_RELOAD, 8'hF0);
    wr(`IDX_CNT, 8'hFD);
    wr(`IDX_CSR, 8'h0A);
    repeat (5) @(posedge clk);
    wr(`IDX_CSR, 8'h02);
    wb(1'b0, `IDX_CNT, 8'h00, b);
    check(b & 32'h0000_00F0, 32'h0000_00F0);
    check(overflowIrq_r, 32'h0000_0001);
    rdc(`IDX_CSR, 8'h03);
    rdc(`IDX_CSR, 8'h02);
    check(overflowIrq_r, 32'h0000_0000);
  endtask

  // period 256-F0=16, high while counter at or below compare FC, channel 1 inverted
  task automatic t_pwm;
    for (int c = 0; c < 4; c++) wr(7'(`IDX_DUTY0 - c), 8'hFC);
    wr(`IDX_OUTCTL, 8'hF2);
    wr(`IDX_CSR, 8'h08);
    repeat (60) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      check(pin_partner_i.per[c], 16);
      check(pin_partner_i.hiW[c], c == 1 ? 3 : 13);
    end
    wr(`IDX_DUTY0, 8'hF8);
    repeat (60) @(posedge clk);
    check(pin_partner_i.hiW[0], 9);
    wr(`IDX_OUTCTL, 8'h00);
  endtask

  task automatic t_event;
    wr(`IDX_RELOAD, 8'hFD);
    wr(`IDX_CSR, 8'h8E);
    wb(1'b0, `IDX_CSR, 8'h00, a);
    repeat (10) @(posedge clk);
    rdc(`IDX_CSR, 8'h8A);
    pin_partner_i.pulse(2);
    rdc(`IDX_CNT, 8'hFF);
    haltMode <= 1'b1;
    wr(`IDX_RELOAD, 8'h10);
    pin_partner_i.pulse(1);
    repeat (3) @(negedge clk);
    check(wakeUp_r, 32'h0000_0001);
    @(posedge clk);
    haltMode <= 1'b0;
    rdc(`IDX_CSR, 8'h8B);
    rdc(`IDX_RELOAD, 8'hFD);
    rdc(`IDX_CNT, 8'hFD);
    wr(`IDX_CSR, 8'h00);
  endtask

  task automatic t_capture;
    wr(`IDX_CNT, 8'h33);
    wr(`IDX_CAPCSR, 8'h04);
    pin_partner_i.capPulse(0);
    rdc(`IDX_CAPCSR, 8'h05);
    check(captureIrq_r, 32'h0000_0001);
    wr(`IDX_CNT, 8'h44);
    pin_partner_i.capPulse(0);
    rdc(`IDX_CAP1, 8'h33);
    rdc(`IDX_CAPCSR, 8'h04);
    wr(`IDX_CAPCSR, 8'h14);
    haltMode <= 1'b1;
    pin_partner_i.capPulse(0);
    @(negedge clk);
    check(wakeUp_r, 32'h0000_0001);
    @(posedge clk);
    haltMode <= 1'b0;
    rdc(`IDX_CAP1, 8'h44);
    // second channel, rising edge, counter still parked at 44
    wr(`IDX_CAPCSR, 8'h20);
    pin_partner_i.capPulse(1);
    rdc(`IDX_CAPCSR, 8'h22);
    rdc(`IDX_CAP2, 8'h44);
    rdc(`IDX_CAPCSR, 8'h20);
  endtask

  // reset for ten cycles, then every scenario in turn
  initial begin
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 9'h000;
    wbSel = 4'h1;
    wbDatW = 32'h0000_0000;
    haltMode = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_force();
    t_divider();
    t_overflow();
    t_pwm();
    t_event();
    t_capture();
    conclude();
  end

  // all scenarios take under two thousand cycles; this span of 8000 cycles is far beyond that
  initial begin
    #200_000;
    bad_count++;
    conclude();
  end
endmodule // pwm_auto_reload_timer_tb
